// >>> rtl/smc_fifo.sv
// smc_fifo: synchronous fifo between the serial receiver and the parser.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module smc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("smc_fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_r;
   logic [AW:0] rd_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid = wr_r != rd_r;
   assign out_data = mem[rd_r[AW-1:0]];
   always_ff @(posedge ref_clk) begin
      if (push)
         mem[wr_r[AW-1:0]] <= in_data;
   end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push)
            wr_r <= wr_r + 1'b1;
         if (pop)
            rd_r <= rd_r + 1'b1;
      end
   end
endmodule : smc_fifo

// >>> rtl/smc_parser.sv
// smc_parser: byte classifier and command executor of the serial monitor.
// assumes received bytes arrive as valid strobes on ref_clk; register
// access uses a simple 16-bit address port with byte-wide data.
`timescale 1ns/1ps
module smc_parser
   import smc_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic key_programmed,
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic user_stop,
   input wire logic [15:0] cpu_pc,
   input wire logic [15:0] cpu_wsel,
   input wire logic [15:0] cpu_pstat,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic locked,
   output logic monitor_idle,
   output logic user_running,
   output logic [15:0] run_pc,
   output logic [15:0] monitor_pc,
   output logic [7:0] live_ser_ctrl,
   output logic [15:0] live_baud,
   output logic [15:0] live_pulse,
   output logic otp_hit,
   output logic [14:0] otp_offset
);
   if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("smc_parser fifo depth too small");
   end

   smc_state_e state_r;
   smc_state_e state_nxt;
   logic started_r;
   logic [7:0] cmd_r;
   logic [7:0] flags_r;
   logic [31:0] data_r;
   logic [15:0] ptr_r;
   logic [15:0] upc_r;
   logic [15:0] uwsel_r;
   logic [15:0] upstat_r;
   logic [7:0] dser_r;
   logic [15:0] dbaud_r;
   logic [15:0] dpulse_r;
   logic [15:0] run_pc_r;
   logic [7:0] live_ser_r;
   logic [15:0] live_baud_r;
   logic [15:0] live_pulse_r;
   logic param_dirty_r;

   logic [7:0] q_byte;
   logic q_valid;
   logic take;

   // received bytes wait here while a command executes or user code runs
   smc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_data(rx_byte),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .out_data(q_byte),
      .out_valid(q_valid),
      .out_ready(take)
   );

   smc_remap u_remap (
      .mon_addr(ptr_r),
      .otp_hit(otp_hit),
      .otp_offset(otp_offset)
   );

   // classification of the byte at the head of the queue
   // nothing leaves the queue before the lock decision has been made
   assign take = q_valid && started_r && state_r == SMC_IDLE;
   wire latch_set = flags_r[DATA_LATCH_BIT];
   wire is_data = q_byte > CMD_MAX || latch_set;
   wire take_data = take && is_data;
   wire take_cmd = take && !is_data;
   wire exec_now = state_r == SMC_EXEC;
   wire do_latch = exec_now && cmd_r == CMD_LATCH_NEXT;
   wire do_to_ptr = exec_now && cmd_r == CMD_BUF_TO_PTR;
   wire do_run = exec_now && cmd_r == CMD_RUN;
   wire stop_user = state_r == SMC_USER && user_stop;

   // register port decode
   wire wr_cmd = reg_wr && reg_addr == ADDR_COMMAND_BYTE;
   wire wr_flags = reg_wr && reg_addr == ADDR_MODE_FLAGS;
   wire [15:0] dofs = reg_addr - ADDR_DATA_BUF;
   wire wr_data = reg_wr && reg_addr >= ADDR_DATA_BUF && dofs < 16'h0004;
   wire [1:0] dlane = dofs[1:0];
   wire wr_ptr_lo = reg_wr && reg_addr == ADDR_TARGET_PTR;
   wire wr_ptr_hi = reg_wr && reg_addr == ADDR_TARGET_PTR + 16'h0001;
   wire wr_pc_lo = reg_wr && reg_addr == ADDR_USER_PC;
   wire wr_pc_hi = reg_wr && reg_addr == ADDR_USER_PC + 16'h0001;
   wire wr_ws_lo = reg_wr && reg_addr == ADDR_USER_WSEL;
   wire wr_ws_hi = reg_wr && reg_addr == ADDR_USER_WSEL + 16'h0001;
   wire wr_ps_lo = reg_wr && reg_addr == ADDR_USER_PSTAT;
   wire wr_ps_hi = reg_wr && reg_addr == ADDR_USER_PSTAT + 16'h0001;
   wire wr_ser = reg_wr && reg_addr == ADDR_SER_CTRL;
   wire wr_bd_lo = reg_wr && reg_addr == ADDR_BAUD;
   wire wr_bd_hi = reg_wr && reg_addr == ADDR_BAUD + 16'h0001;
   wire wr_pw_lo = reg_wr && reg_addr == ADDR_PULSE;
   wire wr_pw_hi = reg_wr && reg_addr == ADDR_PULSE + 16'h0001;
   wire wr_param = wr_ser || wr_bd_lo || wr_bd_hi || wr_pw_lo || wr_pw_hi;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SMC_LOCKED:
            state_nxt = SMC_LOCKED;
         SMC_IDLE:
            if (take_cmd)
               state_nxt = SMC_EXEC;
         SMC_EXEC:
            state_nxt = do_run ? SMC_USER : SMC_IDLE;
         SMC_USER:
            if (user_stop)
               state_nxt = SMC_IDLE;
         default:
            state_nxt = SMC_IDLE;
      endcase
   end

   // entry decision is taken on the first clock after reset release
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         started_r <= 1'b0;
         state_r <= SMC_IDLE;
      end else begin
         started_r <= 1'b1;
         if (!started_r)
            state_r <= key_programmed ? SMC_LOCKED : SMC_IDLE;
         else
            state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset)
         cmd_r <= 8'h00;
      else if (take_cmd)
         cmd_r <= q_byte;
      else if (wr_cmd)
         cmd_r <= reg_wdata;
   end

   // flag clear on data take; a latch command in the same cycle is
   // impossible because execution and taking never overlap
   always_ff @(posedge ref_clk) begin
      if (reset)
         flags_r <= 8'h00;
      else if (do_latch)
         flags_r[DATA_LATCH_BIT] <= 1'b1;
      else if (take_data)
         flags_r[DATA_LATCH_BIT] <= 1'b0;
      else if (wr_flags)
         flags_r <= reg_wdata;
   end

   always_ff @(posedge ref_clk) begin
      if (reset)
         data_r <= 32'h0000_0000;
      else if (take_data)
         data_r <= {data_r[23:0], q_byte};
      else if (wr_data)
         data_r[8*dlane +: 8] <= reg_wdata;
   end

   // addresses are held as 16 bits throughout the monitor
   always_ff @(posedge ref_clk) begin
      if (reset)
         ptr_r <= 16'h0000;
      else if (do_to_ptr)
         ptr_r <= data_r[15:0];
      else if (wr_ptr_lo)
         ptr_r[7:0] <= reg_wdata;
      else if (wr_ptr_hi)
         ptr_r[15:8] <= reg_wdata;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         upc_r <= RST_USER_PC;
         uwsel_r <= RST_USER_WSEL;
         upstat_r <= RST_USER_PSTAT;
      end else if (stop_user) begin
         upc_r <= cpu_pc;
         uwsel_r <= cpu_wsel;
         upstat_r <= cpu_pstat;
      end else begin
         if (wr_pc_lo)
            upc_r[7:0] <= reg_wdata;
         if (wr_pc_hi)
            upc_r[15:8] <= reg_wdata;
         if (wr_ws_lo)
            uwsel_r[7:0] <= reg_wdata;
         if (wr_ws_hi)
            uwsel_r[15:8] <= reg_wdata;
         if (wr_ps_lo)
            upstat_r[7:0] <= reg_wdata;
         if (wr_ps_hi)
            upstat_r[15:8] <= reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset)
         run_pc_r <= RST_USER_PC;
      else if (do_run)
         run_pc_r <= upc_r;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dser_r <= RST_SER_CTRL;
         dbaud_r <= RST_BAUD;
         dpulse_r <= RST_PULSE;
      end else begin
         if (wr_ser)
            dser_r <= reg_wdata;
         if (wr_bd_lo)
            dbaud_r[7:0] <= reg_wdata;
         if (wr_bd_hi)
            dbaud_r[15:8] <= reg_wdata;
         if (wr_pw_lo)
            dpulse_r[7:0] <= reg_wdata;
         if (wr_pw_hi)
            dpulse_r[15:8] <= reg_wdata;
      end
   end

   // copy happens one cycle after the write so all lanes have settled
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         param_dirty_r <= 1'b0;
         live_ser_r <= RST_SER_CTRL;
         live_baud_r <= RST_BAUD;
         live_pulse_r <= RST_PULSE;
      end else begin
         param_dirty_r <= wr_param;
         if (param_dirty_r) begin
            live_ser_r <= dser_r;
            live_baud_r <= dbaud_r;
            live_pulse_r <= dpulse_r;
         end
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      reg_rdata = 8'h00;
      if (reg_addr == ADDR_COMMAND_BYTE)
         reg_rdata = cmd_r;
      else if (reg_addr == ADDR_MODE_FLAGS)
         reg_rdata = flags_r;
      else if (reg_addr >= ADDR_DATA_BUF && dofs < 16'h0004)
         reg_rdata = data_r[8*dlane +: 8];
      else if (reg_addr == ADDR_TARGET_PTR)
         reg_rdata = ptr_r[7:0];
      else if (reg_addr == ADDR_TARGET_PTR + 16'h0001)
         reg_rdata = ptr_r[15:8];
      else if (reg_addr == ADDR_USER_PC)
         reg_rdata = upc_r[7:0];
      else if (reg_addr == ADDR_USER_PC + 16'h0001)
         reg_rdata = upc_r[15:8];
      else if (reg_addr == ADDR_USER_WSEL)
         reg_rdata = uwsel_r[7:0];
      else if (reg_addr == ADDR_USER_WSEL + 16'h0001)
         reg_rdata = uwsel_r[15:8];
      else if (reg_addr == ADDR_USER_PSTAT)
         reg_rdata = upstat_r[7:0];
      else if (reg_addr == ADDR_USER_PSTAT + 16'h0001)
         reg_rdata = upstat_r[15:8];
      else if (reg_addr == ADDR_SER_CTRL)
         reg_rdata = dser_r;
      else if (reg_addr == ADDR_BAUD)
         reg_rdata = dbaud_r[7:0];
      else if (reg_addr == ADDR_BAUD + 16'h0001)
         reg_rdata = dbaud_r[15:8];
      else if (reg_addr == ADDR_PULSE)
         reg_rdata = dpulse_r[7:0];
      else if (reg_addr == ADDR_PULSE + 16'h0001)
         reg_rdata = dpulse_r[15:8];
   end

   assign locked = state_r == SMC_LOCKED;
   assign monitor_idle = state_r == SMC_IDLE;
   assign user_running = state_r == SMC_USER;
   assign run_pc = run_pc_r;
   assign monitor_pc = ADDR_MON_BASE;
   assign live_ser_ctrl = live_ser_r;
   assign live_baud = live_baud_r;
   assign live_pulse = live_pulse_r;

   a_data_shift: assert property (@(posedge ref_clk) disable iff (reset)
      take_data |=> data_r == {$past(data_r[23:0]), $past(q_byte)})
      else $error("data buffer did not shift in byte");
   a_cmd_latch: assert property (@(posedge ref_clk) disable iff (reset)
      take_cmd |=> cmd_r == $past(q_byte) && state_r == SMC_EXEC)
      else $error("command byte not latched");
   a_flag_set: assert property (@(posedge ref_clk) disable iff (reset)
      do_latch |=> flags_r[DATA_LATCH_BIT])
      else $error("latch command did not set flag");
   a_flag_clear: assert property (@(posedge ref_clk) disable iff (reset)
      take_data |=> !flags_r[DATA_LATCH_BIT])
      else $error("flag not cleared after data");
   a_ptr_move: assert property (@(posedge ref_clk) disable iff (reset)
      do_to_ptr |=> ptr_r == $past(data_r[15:0]))
      else $error("pointer not loaded from buffer");
   a_exec_return: assert property (@(posedge ref_clk) disable iff (reset)
      exec_now && !do_run |=> state_r == SMC_IDLE)
      else $error("no return to idle after command");
   a_lock_stay: assert property (@(posedge ref_clk) disable iff (reset)
      locked |=> locked [*3])
      else $error("locked state left");
   a_run_pc: assert property (@(posedge ref_clk) disable iff (reset)
      do_run |=> user_running && run_pc == $past(upc_r))
      else $error("run did not load user pc");
   a_user_save: assert property (@(posedge ref_clk) disable iff (reset)
      stop_user |=> upc_r == $past(cpu_pc) && upstat_r == $past(cpu_pstat))
      else $error("user state not saved on stop");
   a_param_copy: assert property (@(posedge ref_clk) disable iff (reset)
      wr_ser |-> ##2 live_ser_ctrl == $past(reg_wdata, 2))
      else $error("serial control not copied");
endmodule : smc_parser

// >>> rtl/smc_pkg.sv
// smc_pkg: constants shared by the serial monitor command parser.
// assumes a single synchronous clock domain and byte-wide receive data.
package smc_pkg;
   // register addresses in the monitor working area and test rom
   localparam logic [15:0] ADDR_COMMAND_BYTE = 16'h0056;
   localparam logic [15:0] ADDR_MODE_FLAGS = 16'h0057;
   localparam logic [15:0] ADDR_DATA_BUF = 16'h0058;
   localparam logic [15:0] ADDR_TARGET_PTR = 16'h005C;
   localparam logic [15:0] ADDR_USER_PC = 16'h005E;
   localparam logic [15:0] ADDR_USER_WSEL = 16'h0060;
   localparam logic [15:0] ADDR_USER_PSTAT = 16'h0062;
   localparam logic [15:0] ADDR_SER_CTRL = 16'h2215;
   localparam logic [15:0] ADDR_BAUD = 16'h2216;
   localparam logic [15:0] ADDR_PULSE = 16'h221C;
   localparam logic [15:0] ADDR_MON_BASE = 16'h2000;
   // reset values
   localparam logic [15:0] RST_USER_PC = 16'h2080;
   localparam logic [15:0] RST_USER_WSEL = 16'h1000;
   localparam logic [15:0] RST_USER_PSTAT = 16'h0200;
   localparam logic [7:0] RST_SER_CTRL = 8'h09;
   localparam logic [15:0] RST_BAUD = 16'h8067;
   localparam logic [15:0] RST_PULSE = 16'h80FF;
   // field positions and command codes
   localparam int DATA_LATCH_BIT = 0;
   localparam logic [7:0] CMD_MAX = 8'h1F;
   localparam logic [7:0] CMD_LATCH_NEXT = 8'h00;
   localparam logic [7:0] CMD_BUF_TO_PTR = 8'h0A;
   localparam logic [7:0] CMD_RUN = 8'h12;
   localparam logic [7:0] CMD_HALT = 8'h13;
   // otp remap: low 24k window at a000, high 8k window at 8000
   localparam logic [15:0] OTP_LOW_BASE = 16'hA000;
   localparam logic [15:0] OTP_HIGH_BASE = 16'h8000;
   localparam logic [15:0] OTP_HIGH_END = 16'h9FFF;
   localparam logic [15:0] OTP_HIGH_OFS = 16'h6000;
   typedef enum logic [1:0] {SMC_LOCKED, SMC_IDLE, SMC_EXEC, SMC_USER}
      smc_state_e;
endpackage : smc_pkg

// >>> rtl/smc_remap.sv
// smc_remap: translates a 16-bit monitor address to an otp array offset.
// assumes the monitor runs with 16-bit addresses only.
`timescale 1ns/1ps
module smc_remap
   import smc_pkg::*;
(
   input wire logic [15:0] mon_addr,
   output logic otp_hit,
   output logic [14:0] otp_offset
);
   wire low_win = mon_addr >= OTP_LOW_BASE;
   wire high_win = mon_addr >= OTP_HIGH_BASE && mon_addr <= OTP_HIGH_END;
   wire [15:0] low_ofs = mon_addr - OTP_LOW_BASE;
   wire [15:0] high_ofs = mon_addr - OTP_HIGH_BASE + OTP_HIGH_OFS;
   assign otp_hit = low_win || high_win;
   assign otp_offset = low_win ? low_ofs[14:0] : high_ofs[14:0];
endmodule : smc_remap

// >>> testbench/smc_host_model.sv
// smc_host_model: host terminal feeding bytes to the parser's receive side.
// assumes the bench queues bytes through push; drives at the falling edge.
`timescale 1ns/1ps
module smc_host_model (
   input wire logic ref_clk,
   input wire logic rx_ready,
   output logic [7:0] rx_byte,
   output logic rx_valid
);
   logic [7:0] q[$];
   logic took_r;
   int gap = 0;
   int wait_cnt = 0;
   initial begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
      took_r = 1'b0;
   end
   task automatic push(input logic [7:0] b);
      q.push_back(b);
   endtask : push
   // ready is judged at the rising edge; the byte changes only afterwards
   always @(posedge ref_clk) took_r <= rx_valid && rx_ready;
   always @(negedge ref_clk) begin
      if (took_r && q.size() > 0) begin
         void'(q.pop_front());
         wait_cnt = gap;
      end
      if (q.size() > 0 && wait_cnt == 0) begin
         rx_byte = q[0];
         rx_valid = 1'b1;
      end else begin
         if (wait_cnt > 0) wait_cnt--;
         // released line: toggle so a stale byte never looks valid
         rx_byte = ~rx_byte;
         rx_valid = 1'b0;
      end
   end
endmodule : smc_host_model

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for the serial monitor command parser.
// assumes the parser holds its receive fifo and a host model feeds it.
`timescale 1ns/1ps
module tb_top;
   import smc_pkg::*;
   logic ref_clk, reset, key_programmed, rx_valid, rx_ready, user_stop;
   logic reg_wr, locked, monitor_idle, user_running, otp_hit;
   logic [7:0] rx_byte, reg_wdata, reg_rdata, live_ser_ctrl;
   logic [15:0] cpu_pc, cpu_wsel, cpu_pstat, reg_addr, run_pc;
   logic [15:0] monitor_pc, live_baud, live_pulse;
   logic [14:0] otp_offset;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   smc_host_model host (.ref_clk(ref_clk), .rx_ready(rx_ready),
      .rx_byte(rx_byte), .rx_valid(rx_valid));
   smc_parser #(.FIFO_DEPTH(16)) DUT (.ref_clk(ref_clk), .reset(reset),
      .key_programmed(key_programmed), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .user_stop(user_stop),
      .cpu_pc(cpu_pc), .cpu_wsel(cpu_wsel), .cpu_pstat(cpu_pstat),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .locked(locked), .monitor_idle(monitor_idle),
      .user_running(user_running), .run_pc(run_pc),
      .monitor_pc(monitor_pc), .live_ser_ctrl(live_ser_ctrl),
      .live_baud(live_baud), .live_pulse(live_pulse), .otp_hit(otp_hit),
      .otp_offset(otp_offset));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic settle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : settle

   task automatic do_reset(input logic key);
      @(negedge ref_clk);
      reset = 1'b1;
      key_programmed = key;
      settle(6);
      reset = 1'b0;
      settle(2);
   endtask : do_reset

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask : wr

   // little endian: lowest address is the low byte
   task automatic rdn(input logic [15:0] a, input int n,
      output logic [31:0] v);
      v = 32'h0;
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         reg_addr = a + 16'(i);
         #1 v[8*i+:8] = reg_rdata;
      end
   endtask : rdn

   task automatic feed(input logic [7:0] b[$]);
      foreach (b[i]) host.push(b[i]);
      settle(4 * b.size() + 8);
   endtask : feed

   // high byte first; bytes in the command range need a latch prefix
   task automatic send_addr(input logic [15:0] a);
      logic [7:0] q[$];
      for (int i = 1; i >= 0; i--) begin
         if (a[8*i+:8] <= 8'h1F) q.push_back(8'h00);
         q.push_back(a[8*i+:8]);
      end
      q.push_back(8'h0A);
      feed(q);
   endtask : send_addr

   task automatic t_reset();
      logic [31:0] v;
      rdn(16'h005E, 2, v); check(v, 32'h2080);
      rdn(16'h0060, 2, v); check(v, 32'h1000);
      rdn(16'h0062, 2, v); check(v, 32'h0200);
      rdn(16'h2215, 1, v); check(v, 32'h09);
      rdn(16'h2216, 2, v); check(v, 32'h8067);
      rdn(16'h221C, 2, v); check(v, 32'h80FF);
      check(live_ser_ctrl, 32'h09);
      check(live_baud, 32'h8067);
      check(live_pulse, 32'h80FF);
      check(monitor_pc, 32'h2000);
      check({monitor_idle, locked, user_running}, 32'h4);
      check(run_pc, 32'h2080);
   endtask : t_reset

   task automatic t_walk();
      logic [31:0] v;
      host.gap = 2;
      feed('{8'h22, 8'h00, 8'h1C, 8'h0A});
      host.gap = 0;
      rdn(16'h005C, 2, v); check(v, 32'h221C);
      rdn(16'h0058, 4, v); check(v, 32'h221C);
      rdn(16'h0056, 2, v); check(v, 32'h000A);
      feed('{8'h00});
      rdn(16'h0056, 2, v); check(v, 32'h0100);
      feed('{8'h05});
      rdn(16'h0057, 1, v); check(v, 32'h00);
      rdn(16'h0058, 4, v); check(v, 32'h221C05);
      feed('{8'h31, 8'h32, 8'h33, 8'h34, 8'h35});
      rdn(16'h0058, 4, v); check(v, 32'h32333435);
      check(monitor_idle, 32'h1);
   endtask : t_walk

   task automatic t_remap();
      logic [15:0] adr[6] = '{16'hA080, 16'hFFFF, 16'h8000, 16'h9FFF,
         16'h2000, 16'h7FFF};
      logic [15:0] ofs[6] = '{16'h0080, 16'h5FFF, 16'h6000, 16'h7FFF,
         16'h0, 16'h0};
      logic [31:0] v;
      foreach (adr[i]) begin
         send_addr(adr[i]);
         rdn(16'h005C, 2, v); check(v, adr[i]);
         check(otp_hit, 32'(i < 4));
         if (i < 4) check(otp_offset, ofs[i]);
      end
   endtask : t_remap

   task automatic t_unknown();
      logic [31:0] b0, v;
      rdn(16'h0058, 4, b0);
      feed('{8'h1F});
      rdn(16'h0056, 2, v); check(v, 32'h001F);
      rdn(16'h0058, 4, v); check(v, b0);
      rdn(16'h005C, 2, v); check(v, 32'h7FFF);
      check(monitor_idle, 32'h1);
   endtask : t_unknown

   task automatic t_params();
      logic [15:0] pw;
      logic [31:0] v;
      // 0.6944 us pulse at 16 MHz from the host's formula
      pw = 16'h8000 | 16'((6944 * 16) / 10000 - 1);
      wr(16'h2215, 8'h0B);
      wr(16'h221C, pw[7:0]);
      wr(16'h221D, pw[15:8]);
      wr(16'h2216, 8'h33);
      wr(16'h2217, 8'h00);
      wr(16'h1234, 8'h55);
      settle(3);
      check(live_ser_ctrl, 32'h0B);
      check(live_pulse, pw);
      check(live_baud, 32'h0033);
      rdn(16'h1234, 1, v); check(v, 32'h0);
   endtask : t_params

   // user code stalls the queue; it must refuse at 16 and drain after halt
   task automatic t_run_fill();
      logic [31:0] v;
      wr(16'h005E, 8'h00);
      wr(16'h005F, 8'h04);
      feed('{8'h12});
      check({user_running, monitor_idle}, 32'h2);
      check(run_pc, 32'h0400);
      for (int i = 0; i < 17; i++) host.push(8'h40 + 8'(i));
      settle(24);
      check(rx_ready, 32'h0);
      cpu_pc = 16'h1234;
      cpu_wsel = 16'h1055;
      cpu_pstat = 16'h0266;
      user_stop = 1'b1;
      @(negedge ref_clk);
      user_stop = 1'b0;
      settle(80);
      check({user_running, monitor_idle}, 32'h1);
      rdn(16'h005E, 2, v); check(v, 32'h1234);
      rdn(16'h0060, 2, v); check(v, 32'h1055);
      rdn(16'h0062, 2, v); check(v, 32'h0266);
      rdn(16'h0058, 4, v); check(v, 32'h4D4E4F50);
      check(rx_ready, 32'h1);
   endtask : t_run_fill

   task automatic t_lock();
      logic [31:0] v;
      do_reset(1'b1);
      check({locked, monitor_idle}, 32'h2);
      feed('{8'h33});
      check({locked, monitor_idle}, 32'h2);
      rdn(16'h0058, 4, v); check(v, 32'h0);
      do_reset(1'b0);
      check({locked, monitor_idle}, 32'h1);
   endtask : t_lock

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         n_fail++;
         print_verdict();
      end
   end

   initial begin
      reset = 1'b1;
      key_programmed = 1'b0;
      user_stop = 1'b0;
      cpu_pc = 16'h0;
      cpu_wsel = 16'h0;
      cpu_pstat = 16'h0;
      reg_addr = 16'h0;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      do_reset(1'b0);
      t_reset();
      t_walk();
      t_remap();
      t_unknown();
      t_params();
      t_run_fill();
      t_lock();
      print_verdict();
   end
endmodule : tb_top
